// [inc/phy_ctl_map.svh]
// Behaviour
// R1 - duplex-force bit selects forced full or half
// R2 - software keeps duplex-force at zero ideally
// R3 - first control bit 4 advertises pause ability
// R4 - bit 3 advertises 100 full duplex
// R5 - bit 2 advertises 100 half duplex
// R6 - bit 1 advertises 10 full duplex
// R7 - bit 0 advertises 10 half duplex
// R8 - indicator blank drives both indicators high
// R9 - transmit disable bit turns transmitter off
// R10 - writing restart bit restarts negotiation
// R11 - far-end fault disable stops detect and pattern
// R12 - crossover disable bit turns auto crossover off
// R13 - forced wiring: one straight, zero crossed
// R14 - negotiation enable; else speed, duplex forced
// R15 - restart fires once per zero-to-one write
`ifndef PHY_CTL_MAP_SVH
`define PHY_CTL_MAP_SVH
// ----------------------------------------------------------------
// register indices (byte address is four times index)
// ----------------------------------------------------------------
`define IDX_P1_FIRST      8'h1C
`define IDX_P1_SECOND     8'h1D
`define IDX_P2_FIRST      8'h2C
`define IDX_P2_SECOND     8'h2D
`define IDX_P3_SECOND     8'h3D
// ----------------------------------------------------------------
// first control register fields
// ----------------------------------------------------------------
`define F1_AN_EN          7
`define F1_SPEED          6
`define F1_DUPLEX         5
`define F1_PAUSE          4
`define F1_ADV_BASE       0
`define F1_ADV_TOP        3
`define F1_LOW_RST        5'h1F
// ----------------------------------------------------------------
// second control register fields
// ----------------------------------------------------------------
`define F2_BLANK          7
`define F2_TXDIS          6
`define F2_RESTART        5
`define F2_NOFEF          4
`define F2_PDOWN          3
`define F2_NOXOVER        2
`define F2_STRAIGHT       1
`define F2_RST            8'h00
`define RSVD_VALUE        32'h0000_0000
`endif

// [inc/phy_ctl_pkg.sv]
package phy_ctl_pkg;
    // per-port settings toward the phy
    typedef struct packed {
        logic       an_enable;
        logic       force_100;
        logic       force_full;
        logic       adv_pause;
        logic [3:0] adv_ability;
        logic       transmit_off;
        logic       fef_off;
        logic       power_down;
        logic       xover_off;
        logic       force_straight_wiring;
    } port_ctl_t;
    // strap levels sampled at reset release
    typedef struct packed {
        logic an_enable;
        logic force_100;
        logic force_full;
    } strap_t;
endpackage

// [core/phy_port_ctl.sv]
`timescale 1ns/1ps
`default_nettype none
`include "phy_ctl_map.svh"
module phy_port_ctl (
    input  wire logic               pclk,
    input  wire logic               presetn,
    input  wire logic               strap_take,
    input  wire phy_ctl_pkg::strap_t strap,
    input  wire logic               wr_first,
    input  wire logic               wr_second,
    input  wire logic [7:0]         wdata,
    input  wire logic               neg_done,
    input  wire logic               ind_high_in,
    input  wire logic               ind_low_in,
    output logic [7:0]              first_r,
    output logic [7:0]              second_r,
    output phy_ctl_pkg::port_ctl_t  ctl,
    output logic                    duplex_full,
    output logic                    negotiation_restart,
    output logic                    port_indicator_high,
    output logic                    port_indicator_low
);
    // ----------------------------------------------------------------
    // first control register with strap-loaded top bits
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            first_r <= {3'h0, `F1_LOW_RST};
        end else if (strap_take) begin
            first_r[`F1_AN_EN]  <= strap.an_enable;
            first_r[`F1_SPEED]  <= strap.force_100;
            first_r[`F1_DUPLEX] <= strap.force_full;
        end else if (wr_first) begin
            first_r <= wdata;
        end
    end

    // second control register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            second_r <= `F2_RST;
        end else if (wr_second) begin
            second_r <= wdata;
        end
    end

    // one restart pulse per rising write of the restart bit
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            negotiation_restart <= 1'b0;
        end else begin
            negotiation_restart <= wr_second && wdata[`F2_RESTART]
                                   && !second_r[`F2_RESTART]; // R10 R15
        end
    end

    // duplex in force: forced bit unless negotiation succeeded
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            duplex_full <= 1'b0;
        end else if (!first_r[`F1_AN_EN] || !neg_done) begin
            duplex_full <= first_r[`F1_DUPLEX]; // R1 R14
        end else begin
            duplex_full <= 1'b0;
        end
    end

    // indicator outputs, blanked high when asked
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_indicator_high <= 1'b1;
            port_indicator_low  <= 1'b1;
        end else begin
            port_indicator_high <= ind_high_in | second_r[`F2_BLANK]; // R8
            port_indicator_low  <= ind_low_in | second_r[`F2_BLANK];  // R8
        end
    end

    // settings fanned out to the phy
    always_comb begin
        ctl.an_enable             = first_r[`F1_AN_EN];   // R14
        ctl.force_100             = first_r[`F1_SPEED];   // R14
        ctl.force_full            = first_r[`F1_DUPLEX];  // R1
        ctl.adv_pause             = first_r[`F1_PAUSE];   // R3
        ctl.adv_ability           = first_r[`F1_ADV_TOP:`F1_ADV_BASE]; // R4 R5 R6 R7
        ctl.transmit_off          = second_r[`F2_TXDIS];  // R9
        ctl.fef_off               = second_r[`F2_NOFEF];  // R11
        ctl.power_down            = second_r[`F2_PDOWN];
        ctl.xover_off             = second_r[`F2_NOXOVER]; // R12
        ctl.force_straight_wiring = second_r[`F2_NOXOVER] & second_r[`F2_STRAIGHT]; // R13
    end
endmodule // phy_port_ctl
`default_nettype wire

// [core/port_phy_link_control_regs.sv]
// Design decision made here: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "phy_ctl_map.svh"
module port_phy_link_control_regs #(
    parameter int NPORTS = 2
) (
    input  wire logic                   pclk,
    input  wire logic                   presetn,
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [11:0]            paddr,
    input  wire logic [31:0]            pwdata,
    output logic [31:0]                 prdata,
    output logic                        pready,
    output logic                        pslverr,
    input  wire phy_ctl_pkg::strap_t    strap_pins [NPORTS],
    input  wire logic [NPORTS-1:0]      neg_done,
    input  wire logic [NPORTS-1:0]      ind_high_in,
    input  wire logic [NPORTS-1:0]      ind_low_in,
    output phy_ctl_pkg::port_ctl_t      ctl [NPORTS],
    output logic [NPORTS-1:0]           duplex_full,
    output logic [NPORTS-1:0]           negotiation_restart,
    output logic [NPORTS-1:0]           port_indicator_high,
    output logic [NPORTS-1:0]           port_indicator_low
);
    // refuse port counts the decode cannot serve
    if (NPORTS < 1 || NPORTS > 2) begin : g_bad_nports
        $error("NPORTS must be 1 or 2");
    end

    // ----------------------------------------------------------------
    // address decode
    // ----------------------------------------------------------------
    function automatic logic [2:0] decode(input logic [11:0] a);
        // bit0 second register, bits 2:1 port index (3'h6 port3 second); 3'h7 none
        case (a)
            {2'h0, `IDX_P1_FIRST, 2'h0}:  decode = 3'h0;
            {2'h0, `IDX_P1_SECOND, 2'h0}: decode = 3'h1;
            {2'h0, `IDX_P2_FIRST, 2'h0}:  decode = 3'h2;
            {2'h0, `IDX_P2_SECOND, 2'h0}: decode = 3'h3;
            {2'h0, `IDX_P3_SECOND, 2'h0}: decode = 3'h6;
            default:                        decode = 3'h7;
        endcase
    endfunction

    logic [2:0]        sel;
    logic              access;
    logic              sync1_r;
    logic              sync2_r;
    logic [2:0]        strap_s1_r [NPORTS];
    logic [2:0]        strap_s2_r [NPORTS];
    logic              strap_done_r;
    logic              strap_take;
    logic [7:0]        first_r [NPORTS];
    logic [7:0]        second_r [NPORTS];
    logic [NPORTS-1:0] neg_s1_r;
    logic [NPORTS-1:0] neg_s2_r;
    logic [NPORTS-1:0] ih_s1_r;
    logic [NPORTS-1:0] ih_s2_r;
    logic [NPORTS-1:0] il_s1_r;
    logic [NPORTS-1:0] il_s2_r;

    assign sel    = decode(paddr);
    assign access = psel && penable;
    assign pready = 1'b1;

    // strap pins and status pins pass two flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            neg_s1_r <= '0;
            neg_s2_r <= '0;
            ih_s1_r  <= '0;
            ih_s2_r  <= '0;
            il_s1_r  <= '0;
            il_s2_r  <= '0;
        end else begin
            neg_s1_r <= neg_done;
            neg_s2_r <= neg_s1_r;
            ih_s1_r  <= ind_high_in;
            ih_s2_r  <= ih_s1_r;
            il_s1_r  <= ind_low_in;
            il_s2_r  <= il_s1_r;
        end
    end

    // reset release passes two flops before straps are taken
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
        end else begin
            sync1_r <= 1'b1;
            sync2_r <= sync1_r;
        end
    end

    // strap capture once, on the third clock edge after release
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            strap_done_r <= 1'b0;
        end else if (strap_take) begin
            strap_done_r <= 1'b1;
        end
    end
    assign strap_take = !strap_done_r && sync2_r;

    // ----------------------------------------------------------------
    // per-port control instances
    // ----------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < NPORTS; g++) begin : g_port
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    strap_s1_r[g] <= 3'h0;
                    strap_s2_r[g] <= 3'h0;
                end else begin
                    strap_s1_r[g] <= strap_pins[g];
                    strap_s2_r[g] <= strap_s1_r[g];
                end
            end

            phy_port_ctl i_phy_port_ctl (
                .pclk                (pclk),
                .presetn             (presetn),
                .strap_take          (strap_take),
                .strap               (phy_ctl_pkg::strap_t'(strap_s2_r[g])),
                .wr_first            (access && pwrite && sel == 3'(2 * g)),
                .wr_second           (access && pwrite && sel == 3'(2 * g + 1)),
                .wdata               (pwdata[7:0]),
                .neg_done            (neg_s2_r[g]),
                .ind_high_in         (ih_s2_r[g]),
                .ind_low_in          (il_s2_r[g]),
                .first_r             (first_r[g]),
                .second_r            (second_r[g]),
                .ctl                 (ctl[g]),
                .duplex_full         (duplex_full[g]),
                .negotiation_restart (negotiation_restart[g]),
                .port_indicator_high (port_indicator_high[g]),
                .port_indicator_low  (port_indicator_low[g])
            );
        end
    endgenerate

    // ----------------------------------------------------------------
    // read data and error answer
    // ----------------------------------------------------------------
    always_comb begin
        prdata  = `RSVD_VALUE;
        pslverr = 1'b0;
        if (access && !pwrite && sel[2:1] < 2'(NPORTS)) begin
            prdata = {24'h0, sel[0] ? second_r[sel[1]] : first_r[sel[1]]};
        end
        if (access && (sel == 3'h7 || (sel != 3'h6 && sel[2:1] >= 2'(NPORTS)))) begin
            pslverr = 1'b1;
        end
    end
endmodule // port_phy_link_control_regs
`default_nettype wire

// [verif/port_phy_link_control_regs_assertions.sv]
`timescale 1ns/1ps
`default_nettype none
module phy_regs_checker #(
    parameter int NPORTS = 2
) (
    input wire logic                   pclk,
    input wire logic                   presetn,
    input wire logic                   psel,
    input wire logic                   penable,
    input wire logic                   pwrite,
    input wire logic [11:0]            paddr,
    input wire logic [31:0]            pwdata,
    input wire phy_ctl_pkg::port_ctl_t ctl [NPORTS],
    input wire logic [NPORTS-1:0]      duplex_full,
    input wire logic [NPORTS-1:0]      negotiation_restart,
    input wire logic [NPORTS-1:0]      port_indicator_high,
    input wire logic [NPORTS-1:0]      port_indicator_low
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic wr_f0, wr_s0, rst0_r, blank0_r, rise0;
    // port 1 register writes
    assign wr_f0 = psel && penable && pwrite && paddr == 12'h070;
    assign wr_s0 = psel && penable && pwrite && paddr == 12'h074;
    // shadow of stored restart and blank bits
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rst0_r   <= 1'h0;
            blank0_r <= 1'h0;
        end else if (wr_s0) begin
            rst0_r   <= pwdata[5];
            blank0_r <= pwdata[7];
        end
    end
    // write that raises the stored restart bit
    assign rise0 = wr_s0 && pwdata[5] && !rst0_r;
    sequence rise_s; rise0; endsequence
    sequence pulse_s; negotiation_restart[0] ##1 !negotiation_restart[0]; endsequence
    adv_fields_a: assert property (
        wr_f0 |=> {ctl[0].adv_pause, ctl[0].adv_ability} == $past(pwdata[4:0]))
        else $error("advertise fields differ from write");
    tx_off_a: assert property (wr_s0 |=> ctl[0].transmit_off == $past(pwdata[6]))
        else $error("transmit disable differs from write");
    fef_off_a: assert property (wr_s0 |=> ctl[0].fef_off == $past(pwdata[4]))
        else $error("far-end fault disable differs from write");
    xover_off_a: assert property (wr_s0 |=> ctl[0].xover_off == $past(pwdata[2]))
        else $error("crossover disable differs from write");
    straight_wire_a: assert property (wr_s0 |=>
        ctl[0].force_straight_wiring == ($past(pwdata[1]) && $past(pwdata[2])))
        else $error("forced wiring wrong");
    restart_pulse_a: assert property (rise_s |=> pulse_s)
        else $error("restart pulse missing");
    restart_cause_a: assert property (negotiation_restart[0] |-> $past(rise0))
        else $error("restart pulse without rising write");
    blank_ind_a: assert property (blank0_r && $past(blank0_r) |->
        port_indicator_high[0] && port_indicator_low[0])
        else $error("indicators not blanked");
    forced_duplex_a: assert property (!ctl[0].an_enable && !$past(ctl[0].an_enable) |->
        duplex_full[0] == $past(ctl[0].force_full))
        else $error("forced duplex wrong");
endmodule // phy_regs_checker
bind port_phy_link_control_regs phy_regs_checker #(.NPORTS(NPORTS)) i_phy_regs_checker (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .ctl, .duplex_full,
    .negotiation_restart, .port_indicator_high, .port_indicator_low);
`default_nettype wire

// [verif/link_partner_model.sv]
`timescale 1ns/1ps
`default_nettype none
module link_partner_model #(
    parameter int NPORTS     = 2,
    parameter int NEG_CYCLES = 6
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic [NPORTS-1:0] negotiation_restart,
    output logic [NPORTS-1:0]      neg_done,
    output logic [NPORTS-1:0]      ind_high_in,
    output logic [NPORTS-1:0]      ind_low_in
);
    int cnt [NPORTS];
    // link indicator dark (high) until negotiated, other lit (low)
    assign ind_high_in = ~neg_done;
    assign ind_low_in  = '0;
    // negotiation completes some cycles after a restart
    always_ff @(posedge pclk or negedge presetn) begin
        for (int p = 0; p < NPORTS; p++) begin
            if (!presetn) begin
                neg_done[p] <= 1'h0;
                cnt[p]      <= 0;
            end else if (negotiation_restart[p]) begin
                neg_done[p] <= 1'h0;
                cnt[p]      <= NEG_CYCLES;
            end else if (cnt[p] > 0) begin
                cnt[p]      <= cnt[p] - 1;
                neg_done[p] <= (cnt[p] == 1);
            end
        end
    end
endmodule // link_partner_model
`default_nettype wire

// [verif/tb_port_phy_link_control_regs.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_port_phy_link_control_regs;
    logic                   pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0]            paddr;
    logic [31:0]            pwdata, prdata, rd;
    phy_ctl_pkg::strap_t    strap_pins [2];
    phy_ctl_pkg::port_ctl_t ctl [2];
    logic [1:0]             neg_done, ind_high_in, ind_low_in, duplex_full;
    logic [1:0]             negotiation_restart, port_indicator_high, port_indicator_low;
    int                     n_mismatch, n_tests, cycles;
    port_phy_link_control_regs #(.NPORTS(2)) i_port_phy_link_control_regs (.pclk, .presetn,
        .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .strap_pins,
        .neg_done, .ind_high_in, .ind_low_in, .ctl, .duplex_full, .negotiation_restart,
        .port_indicator_high, .port_indicator_low);
    link_partner_model i_link_partner_model (.pclk, .presetn, .negotiation_restart,
        .neg_done, .ind_high_in, .ind_low_in);
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one apb transfer, held until pready
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'h1; pwrite <= wr; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do @(posedge pclk); while (pready !== 1'h1);
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        @(negedge pclk);
    endtask
    task automatic test_done;
        $display("tests %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // strap and reset values, straps held full duplex
    task automatic t_reset;
        logic [11:0] a [4] = '{12'h070, 12'h0B0, 12'h074, 12'h0B4};
        logic [7:0]  e [4] = '{8'h7F, 8'hBF, 8'h00, 8'h00};
        for (int i = 0; i < 4; i++) begin
            apb(1'h0, a[i], 32'h0);
            chk(rd, {24'h0, e[i]});
        end
        chk(duplex_full, 2'h3);
        chk({ctl[1].an_enable, ctl[1].force_100, ctl[1].force_full, ctl[0].an_enable,
             ctl[0].force_100, ctl[0].force_full}, 6'h2B);
        $display("t_reset done");
    endtask
    task automatic t_adv;
        for (int i = 0; i < 5; i++) begin
            apb(1'h1, 12'h070, 32'h7F ^ (32'h1 << i));
            chk({ctl[0].adv_pause, ctl[0].adv_ability}, 5'h1F ^ (5'h1 << i));
        end
        apb(1'h1, 12'h070, 32'h5F);
        repeat (2) @(negedge pclk);
        chk(duplex_full[0], 1'h0);
        apb(1'h1, 12'h070, 32'h7F);
        $display("t_adv done");
    endtask
    task automatic t_second;
        logic [7:0] v [5] = '{8'h40, 8'h10, 8'h04, 8'h06, 8'h02};
        for (int i = 0; i < 5; i++) begin
            apb(1'h1, 12'h074, {24'h0, v[i]});
            chk({ctl[0].transmit_off, ctl[0].fef_off, ctl[0].xover_off,
                 ctl[0].force_straight_wiring}, {v[i][6], v[i][4], v[i][2], v[i][2] & v[i][1]});
        end
        apb(1'h1, 12'h074, 32'h0);
        $display("t_second done");
    endtask
    task automatic t_restart;
        for (int p = 0; p < 2; p++) begin
            apb(1'h1, 12'h074 + 12'h040 * p, 32'h20);
            chk(negotiation_restart, 2'h1 << p);
            @(negedge pclk);
            chk(negotiation_restart, 2'h0);
            apb(1'h1, 12'h074 + 12'h040 * p, 32'h20);
            chk(negotiation_restart, 2'h0);
            apb(1'h1, 12'h074 + 12'h040 * p, 32'h0);
        end
        repeat (12) @(negedge pclk);
        chk(duplex_full, 2'h1);
        $display("t_restart done");
    endtask
    task automatic t_blank;
        apb(1'h1, 12'h074, 32'h80);
        repeat (4) @(negedge pclk);
        chk({port_indicator_high, port_indicator_low}, {~neg_done[1], 3'h5});
        apb(1'h1, 12'h074, 32'h0);
        repeat (4) @(negedge pclk);
        chk({port_indicator_high, port_indicator_low}, {~neg_done, 2'h0});
        $display("t_blank done");
    endtask
    task automatic t_refuse;
        apb(1'h1, 12'h0F4, 32'hFF);
        apb(1'h0, 12'h0F4, 32'h0);
        chk(rd, 32'h0);
        chk(err, 1'h0);
        apb(1'h0, 12'h100, 32'h0);
        chk(err, 1'h1);
        $display("t_refuse done");
    endtask
    // free-running clock
    initial begin
        pclk = 1'h0;
        forever #4 pclk = ~pclk;
    end
    // hang guard
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 5000) begin
            n_mismatch++;
            test_done();
        end
    end
    initial begin
        presetn = 1'h0; psel = 1'h0; penable = 1'h0; pwrite = 1'h0;
        paddr = 12'h0; pwdata = 32'h0;
        strap_pins[0] = 3'h3;
        strap_pins[1] = 3'h5;
        repeat (6) @(posedge pclk);
        presetn <= 1'h1;
        repeat (4) @(posedge pclk);
        t_reset();
        t_adv();
        t_second();
        t_restart();
        t_blank();
        t_refuse();
        test_done();
    end
endmodule // tb_port_phy_link_control_regs
`default_nettype wire
